// >>> src/sadc_rx.sv
`timescale 1ns/1ps

// Behaviour
// - Pin control: only I2S at 32/48/64 fs
// - Register control adds left/right justified formats
// - I2S: frame select low left, high right
// - I2S data starts one bit after edge
// - I2S: MSB first, rising edge capture
// - Justified: frame select high left, low right
// - Left justified: data starts at the edge
// - Justified: MSB first, rising edge capture
// - Left justified 16-24 bits, trailing zero fill
// - Right justified 24-bit starts 8 bits late
// - Right justified: LSB in last slot bit
// - Right justified: leading positions zero filled
// - High-pass filter removes DC at path head
// - Pin control: filter always on
// - Register control: bypass bit skips filter
// - DC on output: stage off, latched fault
// - Double speed only under register control
// - Shutdown, fault, soft clip pins always work
module sadc_rx (
    // System
    input wire logic ref_clk,
    input wire logic rst_b,
    // Serial audio link
    input wire logic bit_clk,
    input wire logic frame_select,
    input wire logic serial_data,
    // Control pins
    input wire logic sw_ctrl,
    input wire sadc_pkg::sadc_fmt_t fmt_sel,
    input wire logic [1:0] wlen_sel,
    input wire logic hpf_bypass,
    input wire logic double_speed,
    input wire logic soft_clip_select,
    input wire logic amp_shutdown_n,
    // Audio out
    output sadc_pkg::sadc_word_t sample_q,
    output logic sample_valid_q,
    // Status
    output logic speed_double_q,
    output logic soft_clip_q,
    output logic amp_enable_q,
    output logic dc_error_q,
    output logic amp_fault_n_o_q,
    output logic amp_fault_oe_n_q
);

    function automatic logic [6:0] wlen_bits(input logic [1:0] sel);
        unique case (sel)
            sadc_pkg::SADC_WLEN_16: wlen_bits = sadc_pkg::SADC_BITS_16;
            sadc_pkg::SADC_WLEN_18: wlen_bits = sadc_pkg::SADC_BITS_18;
            sadc_pkg::SADC_WLEN_20: wlen_bits = sadc_pkg::SADC_BITS_20;
            sadc_pkg::SADC_WLEN_24: wlen_bits = sadc_pkg::SADC_BITS_24;
        endcase
    endfunction

    function automatic logic [23:0] mag(input logic [23:0] v);
        mag = v[23] ? 24'(-v) : v;
    endfunction

    // --------------------------------------------------------------------
    // Link domain: configuration crossing
    // --------------------------------------------------------------------
    sadc_pkg::sadc_cfg_t cfg_meta_q, cfg_l_q;
    logic sw_meta_l_q, sw_l_q;

    always_ff @(posedge bit_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_meta_q <= '{sadc_pkg::SADC_FMT_I2S, sadc_pkg::SADC_WLEN_24};
            cfg_l_q <= '{sadc_pkg::SADC_FMT_I2S, sadc_pkg::SADC_WLEN_24};
            sw_meta_l_q <= 1'b0;
            sw_l_q <= 1'b0;
        end else begin
            cfg_meta_q <= '{fmt_sel, wlen_sel};
            cfg_l_q <= cfg_meta_q;
            sw_meta_l_q <= sw_ctrl;
            sw_l_q <= sw_meta_l_q;
        end
    end

    sadc_pkg::sadc_fmt_t fmt_eff;
    logic [6:0] word_bits;
    logic [6:0] data_off;

    always_comb begin
        fmt_eff = sadc_pkg::SADC_FMT_I2S;
        word_bits = sadc_pkg::SADC_BITS_24;
        if (sw_l_q) begin
            fmt_eff = cfg_l_q.fmt;
            word_bits = wlen_bits(cfg_l_q.wlen);
        end
        data_off = (fmt_eff == sadc_pkg::SADC_FMT_I2S) ? sadc_pkg::SADC_I2S_DELAY
                                                       : sadc_pkg::SADC_NO_DELAY;
    end

    // --------------------------------------------------------------------
    // Link domain: slot decoder
    // --------------------------------------------------------------------
    logic fs_prev_q, started_q, tog_l_q;
    logic [6:0] cnt_q;
    logic [23:0] acc_q, acc_d;
    sadc_pkg::sadc_word_t hold_q, done_word;
    logic slot_edge;
    logic [6:0] cur_cnt, idx;
    logic [23:0] rj_mask;

    assign slot_edge = frame_select != fs_prev_q;

    always_comb begin
        cur_cnt = slot_edge ? sadc_pkg::SADC_NO_DELAY : cnt_q;
        idx = cur_cnt - data_off;
        rj_mask = ~(24'hffffff << word_bits);
        acc_d = slot_edge ? 24'h000000 : acc_q;
        if (fmt_eff == sadc_pkg::SADC_FMT_RIGHT_JUSTIFIED) begin
            // Last bit before the next edge lands in bit 0
            acc_d = {acc_d[22:0], serial_data};
        end else if (cur_cnt >= data_off && idx < word_bits) begin
            acc_d[5'(sadc_pkg::SADC_TOP_BIT - idx)] = serial_data;
        end
        done_word.data = (fmt_eff == sadc_pkg::SADC_FMT_RIGHT_JUSTIFIED)
                         ? (acc_q & rj_mask) : acc_q;
        // Finished slot belongs to the previous frame select level
        done_word.right = (fmt_eff == sadc_pkg::SADC_FMT_I2S)
                          ? fs_prev_q : !fs_prev_q;
    end

    always_ff @(posedge bit_clk or negedge rst_b) begin
        if (!rst_b) begin
            fs_prev_q <= 1'b0;
            started_q <= 1'b0;
            cnt_q <= sadc_pkg::SADC_NO_DELAY;
            acc_q <= 24'h000000;
        end else begin
            fs_prev_q <= frame_select;
            acc_q <= acc_d;
            if (slot_edge) begin
                started_q <= 1'b1;
                cnt_q <= sadc_pkg::SADC_CNT_FIRST;
            end else if (cnt_q != sadc_pkg::SADC_CNT_MAX) begin
                cnt_q <= cnt_q + sadc_pkg::SADC_CNT_FIRST;
            end
        end
    end

    // Held word stays stable a whole slot while the toggle crosses
    always_ff @(posedge bit_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_q <= '0;
            tog_l_q <= 1'b0;
        end else if (slot_edge && started_q) begin
            hold_q <= done_word;
            tog_l_q <= ~tog_l_q;
        end
    end

    // --------------------------------------------------------------------
    // Reference domain: pin and event synchronisers
    // --------------------------------------------------------------------
    logic [4:0] pin_meta_q, pin_s_q;
    logic tog_meta_q, tog_s_q, tog_old_q, sd_old_q;
    logic sw_s, byp_s, dbl_s, clip_s, sd_s;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_q <= 5'h00;
            pin_s_q <= 5'h00;
            tog_meta_q <= 1'b0;
            tog_s_q <= 1'b0;
            tog_old_q <= 1'b0;
            sd_old_q <= 1'b0;
        end else begin
            pin_meta_q <= {sw_ctrl, hpf_bypass, double_speed, soft_clip_select, amp_shutdown_n};
            pin_s_q <= pin_meta_q;
            tog_meta_q <= tog_l_q;
            tog_s_q <= tog_meta_q;
            tog_old_q <= tog_s_q;
            sd_old_q <= sd_s;
        end
    end

    assign {sw_s, byp_s, dbl_s, clip_s, sd_s} = pin_s_q;

    // --------------------------------------------------------------------
    // Reference domain: word capture and mode outputs
    // --------------------------------------------------------------------
    sadc_pkg::sadc_word_t in_q;
    logic in_valid_q, byp_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_q <= '0;
            in_valid_q <= 1'b0;
        end else begin
            in_valid_q <= tog_s_q ^ tog_old_q;
            if (tog_s_q ^ tog_old_q) begin
                in_q <= hold_q;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            byp_q <= 1'b0;
            speed_double_q <= 1'b0;
            soft_clip_q <= 1'b0;
        end else begin
            byp_q <= sw_s && byp_s;
            speed_double_q <= sw_s && dbl_s;
            soft_clip_q <= clip_s;
        end
    end

    // --------------------------------------------------------------------
    // High-pass filter, one state pair per channel
    // --------------------------------------------------------------------
    logic signed [23:0] xp_q [2];
    logic signed [23:0] yp_q [2];
    logic signed [26:0] hp_sum;
    logic signed [23:0] hp_y;

    always_comb begin
        hp_sum = 27'(signed'(in_q.data)) - 27'(xp_q[in_q.right]) + 27'(yp_q[in_q.right])
                 - 27'(yp_q[in_q.right] >>> sadc_pkg::SADC_HPF_SHIFT);
        if (hp_sum > sadc_pkg::SADC_SAT_POS) begin
            hp_y = 24'(sadc_pkg::SADC_SAT_POS);
        end else if (hp_sum < sadc_pkg::SADC_SAT_NEG) begin
            hp_y = 24'(sadc_pkg::SADC_SAT_NEG);
        end else begin
            hp_y = 24'(hp_sum);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            xp_q <= '{24'sh000000, 24'sh000000};
            yp_q <= '{24'sh000000, 24'sh000000};
            sample_q <= '0;
            sample_valid_q <= 1'b0;
        end else begin
            sample_valid_q <= in_valid_q;
            if (in_valid_q) begin
                xp_q[in_q.right] <= signed'(in_q.data);
                yp_q[in_q.right] <= hp_y;
                sample_q.right <= in_q.right;
                sample_q.data <= byp_q ? in_q.data : hp_y;
            end
        end
    end

    // --------------------------------------------------------------------
    // DC detector and latching fault
    // --------------------------------------------------------------------
    logic [11:0] dc_cnt_q [2];
    logic dc_sign_q [2];
    logic dc_hit;

    assign dc_hit = sample_valid_q && dc_cnt_q[sample_q.right] == sadc_pkg::SADC_DC_LIMIT;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dc_cnt_q <= '{12'h000, 12'h000};
            dc_sign_q <= '{1'b0, 1'b0};
        end else if (sample_valid_q) begin
            dc_sign_q[sample_q.right] <= sample_q.data[23];
            if (mag(sample_q.data) >= sadc_pkg::SADC_DC_THRESH
                && sample_q.data[23] == dc_sign_q[sample_q.right]
                && !dc_hit) begin
                dc_cnt_q[sample_q.right] <= dc_cnt_q[sample_q.right] + 12'h001;
            end else begin
                dc_cnt_q[sample_q.right] <= 12'h000;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dc_error_q <= 1'b0;
        end else if (dc_hit) begin
            dc_error_q <= 1'b1;
        end else if (sd_s && !sd_old_q) begin
            dc_error_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            amp_enable_q <= 1'b0;
            amp_fault_n_o_q <= 1'b0;
            amp_fault_oe_n_q <= 1'b1;
        end else begin
            amp_enable_q <= sd_s && !dc_error_q && !dc_hit;
            amp_fault_n_o_q <= 1'b0;
            amp_fault_oe_n_q <= !(dc_error_q || dc_hit);
        end
    end

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    property p_hw_i2s_only;
        @(posedge bit_clk) disable iff (!rst_b)
        !sw_l_q |-> fmt_eff == sadc_pkg::SADC_FMT_I2S && data_off == sadc_pkg::SADC_I2S_DELAY;
    endproperty
    a_hw_i2s_only: assert property (p_hw_i2s_only) else $error("pin control not I2S");

    property p_cnt_restart;
        @(posedge bit_clk) disable iff (!rst_b)
        slot_edge |=> cnt_q == sadc_pkg::SADC_CNT_FIRST;
    endproperty
    a_cnt_restart: assert property (p_cnt_restart) else $error("counter not restarted");

    property p_rj_lead_zero;
        @(posedge bit_clk) disable iff (!rst_b)
        slot_edge && started_q && fmt_eff == sadc_pkg::SADC_FMT_RIGHT_JUSTIFIED
        && word_bits == sadc_pkg::SADC_BITS_16 |=> hold_q.data[23:16] == 8'h00;
    endproperty
    a_rj_lead_zero: assert property (p_rj_lead_zero) else $error("leading bits not zero");

    property p_channel_map;
        @(posedge bit_clk) disable iff (!rst_b)
        slot_edge && started_q |=>
        hold_q.right == ((fmt_eff == sadc_pkg::SADC_FMT_I2S) ? $past(fs_prev_q) : !$past(fs_prev_q));
    endproperty
    a_channel_map: assert property (p_channel_map) else $error("wrong channel");

    property p_hpf_forced;
        @(posedge ref_clk) disable iff (!rst_b)
        !sw_s [*2] |-> !byp_q;
    endproperty
    a_hpf_forced: assert property (p_hpf_forced) else $error("filter bypassed in pin mode");

    sequence s_bypassed_sample;
        in_valid_q && byp_q;
    endsequence
    property p_bypass_pass;
        @(posedge ref_clk) disable iff (!rst_b)
        s_bypassed_sample |=> sample_valid_q && sample_q.data == $past(in_q.data);
    endproperty
    a_bypass_pass: assert property (p_bypass_pass) else $error("bypass altered sample");

    property p_single_speed;
        @(posedge ref_clk) disable iff (!rst_b)
        !sw_s |=> !speed_double_q;
    endproperty
    a_single_speed: assert property (p_single_speed) else $error("double speed in pin mode");

    sequence s_fault_raised;
        dc_hit ##1 dc_error_q;
    endsequence
    property p_fault_stage_off;
        @(posedge ref_clk) disable iff (!rst_b)
        s_fault_raised |-> !amp_enable_q && !amp_fault_oe_n_q;
    endproperty
    a_fault_stage_off: assert property (p_fault_stage_off) else $error("fault left stage on");

    property p_fault_latched;
        @(posedge ref_clk) disable iff (!rst_b)
        dc_error_q && !(sd_s && !sd_old_q) |=> dc_error_q;
    endproperty
    a_fault_latched: assert property (p_fault_latched) else $error("fault not latched");

endmodule

// >>> inc/sadc_pkg.sv
package sadc_pkg;

    // --------------------------------------------------------------------
    // Formats and word lengths
    // --------------------------------------------------------------------
    typedef enum logic [1:0] {
        SADC_FMT_I2S,
        SADC_FMT_LEFT_JUSTIFIED,
        SADC_FMT_RIGHT_JUSTIFIED
    } sadc_fmt_t;

    localparam int SADC_WORD_W = 24;
    localparam int SADC_CNT_W = 7;
    localparam logic [6:0] SADC_CNT_MAX = 7'h7f;
    localparam logic [6:0] SADC_CNT_FIRST = 7'h01;
    localparam logic [6:0] SADC_I2S_DELAY = 7'h01;
    localparam logic [6:0] SADC_NO_DELAY = 7'h00;
    localparam logic [1:0] SADC_WLEN_16 = 2'h0;
    localparam logic [1:0] SADC_WLEN_18 = 2'h1;
    localparam logic [1:0] SADC_WLEN_20 = 2'h2;
    localparam logic [1:0] SADC_WLEN_24 = 2'h3;
    localparam logic [6:0] SADC_BITS_16 = 7'h10;
    localparam logic [6:0] SADC_BITS_18 = 7'h12;
    localparam logic [6:0] SADC_BITS_20 = 7'h14;
    localparam logic [6:0] SADC_BITS_24 = 7'h18;
    localparam logic [6:0] SADC_TOP_BIT = 7'h17;

    // --------------------------------------------------------------------
    // High-pass filter and DC detector
    // --------------------------------------------------------------------
    localparam int SADC_ACC_W = 27;
    localparam int SADC_HPF_SHIFT = 10;
    localparam logic signed [26:0] SADC_SAT_POS = 27'sh07fffff;
    localparam logic signed [26:0] SADC_SAT_NEG = -27'sh0800000;
    localparam logic [23:0] SADC_DC_THRESH = 24'h100000;
    localparam logic [11:0] SADC_DC_LIMIT = 12'h7ff;

    // --------------------------------------------------------------------
    // Carriers
    // --------------------------------------------------------------------
    typedef struct packed {
        sadc_fmt_t fmt;
        logic [1:0] wlen;
    } sadc_cfg_t;

    typedef struct packed {
        logic right;
        logic [23:0] data;
    } sadc_word_t;

endpackage

// >>> tb/sadc_src.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Upstream audio source
// ------------------------------------------------------------
module sadc_src (
    // Serial audio link
    output logic bit_clk,
    output logic frame_select,
    output logic serial_data
);
    initial begin
        bit_clk = 1'b0;
        frame_select = 1'b0;
        serial_data = 1'b0;
    end

    // One slot of half a frame; the bit clock stands still outside frames
    task automatic slot(input logic lvl, input int f, input int half, input int n,
                        input logic [23:0] d);
        for (int k = 0; k < half; k++) begin
            frame_select = lvl;
            if (f == 0 && k >= 1 && k <= n) begin
                serial_data = d[n - k];
            end else if (f == 1 && k < n) begin
                serial_data = d[n - 1 - k];
            end else if (f == 2 && k >= half - n) begin
                serial_data = d[half - 1 - k];
            end else begin
                serial_data = ~serial_data;
            end
            #6 bit_clk = 1'b1;
            #6 bit_clk = 1'b0;
        end
    endtask

    // Ratio is 32, 48 or 64 bit clocks a frame
    task automatic frame(input int f, input int ratio, input int n, input logic [23:0] l,
                         input logic [23:0] r);
        logic left_lvl;
        left_lvl = (f != 0);
        slot(left_lvl, f, ratio / 2, n, l);
        slot(~left_lvl, f, ratio / 2, n, r);
    endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic ref_clk, rst_b, sw_ctrl, hpf_bypass, double_speed, soft_clip_select;
    logic amp_shutdown_n, bit_clk, frame_select, serial_data, sample_valid_q;
    logic speed_double_q, soft_clip_q, amp_enable_q, dc_error_q, amp_fault_n_o_q;
    logic amp_fault_oe_n_q;
    logic [1:0] wlen_sel;
    logic [23:0] lq[$];
    logic [23:0] rq[$];
    sadc_pkg::sadc_fmt_t fmt_sel;
    sadc_pkg::sadc_word_t sample_q;
    int error_cnt, checked, cyc;

    sadc_rx i_sadc_rx (
        .ref_clk(ref_clk), .rst_b(rst_b), .bit_clk(bit_clk), .frame_select(frame_select),
        .serial_data(serial_data), .sw_ctrl(sw_ctrl), .fmt_sel(fmt_sel),
        .wlen_sel(wlen_sel), .hpf_bypass(hpf_bypass), .double_speed(double_speed),
        .soft_clip_select(soft_clip_select), .amp_shutdown_n(amp_shutdown_n),
        .sample_q(sample_q), .sample_valid_q(sample_valid_q),
        .speed_double_q(speed_double_q), .soft_clip_q(soft_clip_q),
        .amp_enable_q(amp_enable_q), .dc_error_q(dc_error_q),
        .amp_fault_n_o_q(amp_fault_n_o_q), .amp_fault_oe_n_q(amp_fault_oe_n_q)
    );

    sadc_src i_sadc_src (
        .bit_clk(bit_clk), .frame_select(frame_select), .serial_data(serial_data)
    );

    // ------------------------------------------------------------
    // Clock, sample capture and hang guard
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (sample_valid_q === 1'b1) begin
            if (sample_q.right === 1'b1) rq.push_back(sample_q.data);
            else lq.push_back(sample_q.data);
        end
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            $display("BAD run length expected below 90000 seen %0d", cyc);
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cfg(input logic sw, input int f, input logic [1:0] w, input logic byp);
        @(negedge ref_clk);
        sw_ctrl = sw;
        fmt_sel = sadc_pkg::sadc_fmt_t'(f[1:0]);
        wlen_sel = w;
        hpf_bypass = byp;
        repeat (6) @(negedge ref_clk);
    endtask

    task automatic run(input int f, input int ratio, input int n, input logic [23:0] l,
                       input logic [23:0] r, input int cnt);
        repeat (cnt) i_sadc_src.frame(f, ratio, n, l, r);
        repeat (10) @(negedge ref_clk);
    endtask

    task automatic fcase(input int f, input int ratio, input int n, input logic [1:0] w,
                         input logic [23:0] l, r, el, er);
        cfg(1'b1, f, w, 1'b1);
        run(f, ratio, n, l, r, 3);
        chk("left word", el, lq[$]);
        chk("right word", er, rq[$]);
        $display("test format %0d ratio %0d width %0d done", f, ratio, n);
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        sw_ctrl = 1'b0;
        fmt_sel = sadc_pkg::SADC_FMT_LEFT_JUSTIFIED;
        wlen_sel = 2'h0;
        hpf_bypass = 1'b1;
        double_speed = 1'b1;
        soft_clip_select = 1'b1;
        amp_shutdown_n = 1'b1;
        repeat (10) @(negedge ref_clk);
        chk("fault oe_n in reset", 24'h1, amp_fault_oe_n_q);
        chk("enable in reset", 24'h0, amp_enable_q);
        rst_b = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk("enable", 24'h1, amp_enable_q);
        chk("soft clip", 24'h1, soft_clip_q);
        chk("double speed pin mode", 24'h0, speed_double_q);
        $display("test reset done");
        // Pin control ignores format, width and bypass inputs
        run(0, 64, 24, 24'h400000, 24'h400000, 4);
        chk("filter first", 24'h400000, lq[0]);
        chk("filter second", 24'h3ff000, lq[1]);
        $display("test pin mode done");
        fcase(0, 64, 24, 2'h3, 24'ha5c3e1, 24'h5a3c1e, 24'ha5c3e1, 24'h5a3c1e);
        chk("double speed sw mode", 24'h1, speed_double_q);
        fcase(0, 48, 16, 2'h0, 24'h8123, 24'h7ffe, 24'h812300, 24'h7ffe00);
        fcase(1, 48, 20, 2'h2, 24'h9abcd, 24'h12345, 24'h9abcd0, 24'h123450);
        fcase(1, 64, 16, 2'h0, 24'hc001, 24'h0ff0, 24'hc00100, 24'h0ff000);
        fcase(2, 64, 24, 2'h3, 24'h876543, 24'h13579b, 24'h876543, 24'h13579b);
        fcase(2, 48, 18, 2'h1, 24'h2abcd, 24'h1fedc, 24'h02abcd, 24'h01fedc);
        soft_clip_select = 1'b0;
        repeat (5) @(negedge ref_clk);
        chk("soft clip off", 24'h0, soft_clip_q);
        // Large constant input with the filter bypassed trips the DC detector
        cfg(1'b1, 1, 2'h0, 1'b1);
        run(1, 32, 16, 24'h4000, 24'h4000, 2040);
        chk("dc before limit", 24'h0, dc_error_q);
        run(1, 32, 16, 24'h4000, 24'h4000, 20);
        chk("dc error", 24'h1, dc_error_q);
        chk("stage off", 24'h0, amp_enable_q);
        chk("fault oe_n", 24'h0, amp_fault_oe_n_q);
        chk("fault value", 24'h0, amp_fault_n_o_q);
        amp_shutdown_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk("fault held", 24'h1, dc_error_q);
        amp_shutdown_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        chk("fault cleared", 24'h0, dc_error_q);
        chk("stage on", 24'h1, amp_enable_q);
        chk("fault released", 24'h1, amp_fault_oe_n_q);
        $display("test dc fault done");
        test_done();
    end
endmodule
